// ---- ext_lock_pkg.sv ----
package ext_lock_pkg;

  localparam int          LOCK_W            = 16;
  localparam logic [7:0]  CMD_EXT_LOCK      = 8'hdd;
  localparam logic [7:0]  CMD_WRITE_PROTECT = 8'h10;

  // Lock word bit positions
  localparam int          BIT_UNUSED        = 15;
  localparam int          BIT_PROTECT       = 14;
  localparam int          BIT_WARNING       = 10;
  localparam int          BIT_CUR_TEMP      = 9;
  localparam int          BIT_MARGIN        = 8;
  localparam int          BIT_OPERATION     = 7;
  localparam int          BIT_DEVICE_CFG    = 6;
  localparam int          BIT_INPUT_FAULT   = 5;
  localparam int          BIT_SEQUENCING    = 4;
  localparam int          BIT_MAKER_DATA    = 3;
  localparam int          BIT_PASSKEY       = 2;
  localparam int          BIT_RESTORE       = 1;
  localparam int          BIT_STORE         = 0;

  localparam logic [15:0] LOCK_RESET        = 16'h0000;
  localparam logic [15:0] LOCK_WRITE_MASK   = 16'h7fff;

  // Command codes of the locked groups
  localparam logic [7:0]  CMD_OPERATION     = 8'h01;
  localparam logic [7:0]  CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0]  CMD_STORE_ALL     = 8'h15;
  localparam logic [7:0]  CMD_RESTORE_ALL   = 8'h16;
  localparam logic [7:0]  CMD_ALERT_MASK    = 8'h1b;
  localparam logic [7:0]  CMD_MARGIN_HIGH   = 8'h25;
  localparam logic [7:0]  CMD_MARGIN_LOW    = 8'h26;
  localparam logic [7:0]  CMD_TRANS_RATE    = 8'h27;
  localparam logic [7:0]  CMD_FREQ_SWITCH   = 8'h33;
  localparam logic [7:0]  CMD_VIN_ON        = 8'h35;
  localparam logic [7:0]  CMD_VIN_OFF       = 8'h36;
  localparam logic [7:0]  CMD_VOUT_OV_WARN  = 8'h42;
  localparam logic [7:0]  CMD_VOUT_UV_WARN  = 8'h43;
  localparam logic [7:0]  CMD_IOUT_OC_FAULT = 8'h46;
  localparam logic [7:0]  CMD_IOUT_OC_RESP  = 8'h47;
  localparam logic [7:0]  CMD_IOUT_OC_WARN  = 8'h4a;
  localparam logic [7:0]  CMD_OT_FAULT      = 8'h4f;
  localparam logic [7:0]  CMD_OT_RESP       = 8'h50;
  localparam logic [7:0]  CMD_OT_WARN       = 8'h51;
  localparam logic [7:0]  CMD_VIN_OV_FAULT  = 8'h55;
  localparam logic [7:0]  CMD_TON_DELAY     = 8'h60;
  localparam logic [7:0]  CMD_TON_RISE      = 8'h61;
  localparam logic [7:0]  CMD_TOFF_DELAY    = 8'h64;
  localparam logic [7:0]  CMD_TOFF_FALL     = 8'h65;
  localparam logic [7:0]  CMD_MAKER_ID      = 8'h99;
  localparam logic [7:0]  CMD_MAKER_MODEL   = 8'h9a;
  localparam logic [7:0]  CMD_MAKER_REV     = 8'h9b;

endpackage : ext_lock_pkg

// ---- extended_write_protect_lock.sv ----
`timescale 1ns/1ps
`default_nettype none
module extended_write_protect_lock #(
  parameter logic [7:0] CMD_PASSKEY     = 8'hf0,
  parameter logic [7:0] CMD_USER_SYSCFG = 8'hf1,
  parameter logic [7:0] CMD_BUS_ADDR    = 8'hf2,
  parameter logic [7:0] CMD_COMP        = 8'hf3
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  input  wire logic        i_ce,
  input  wire logic        i_wr_valid,
  input  wire logic [7:0]  i_cmd_code,
  input  wire logic [15:0] i_wr_data,
  input  wire logic        i_std_protect_block,
  input  wire logic        i_nvm_load_valid,
  input  wire logic [15:0] i_nvm_load_data,
  input  wire logic        i_store_done,
  output logic             o_wr_accept,
  output logic             o_wr_refuse,
  output logic [15:0]      o_lock_word,
  output logic             o_store_lock_active,
  output logic             o_store_allow,
  output logic             o_restore_allow,
  output logic             o_passkey_unlock_allow
);

  logic [15:0] extended_write_lock;
  logic        store_lock_eff;
  logic        store_pending;

  function automatic logic in_set(input logic [7:0] c, input logic [7:0] a, input logic [7:0] b,
                                  input logic [7:0] d, input logic [7:0] e, input logic [7:0] f);
    in_set = (c == a) || (c == b) || (c == d) || (c == e) || (c == f);
  endfunction : in_set

  wire logic [7:0] c = i_cmd_code;
  wire logic warning_cfg_lock      = extended_write_lock[ext_lock_pkg::BIT_WARNING];
  wire logic current_temp_fault_lock = extended_write_lock[ext_lock_pkg::BIT_CUR_TEMP];
  wire logic margin_cfg_lock       = extended_write_lock[ext_lock_pkg::BIT_MARGIN];
  wire logic operation_cmd_lock    = extended_write_lock[ext_lock_pkg::BIT_OPERATION];
  wire logic device_cfg_lock       = extended_write_lock[ext_lock_pkg::BIT_DEVICE_CFG];
  wire logic input_fault_cfg_lock  = extended_write_lock[ext_lock_pkg::BIT_INPUT_FAULT];
  wire logic sequencing_cfg_lock   = extended_write_lock[ext_lock_pkg::BIT_SEQUENCING];
  wire logic maker_data_lock       = extended_write_lock[ext_lock_pkg::BIT_MAKER_DATA];
  wire logic passkey_cmd_lock      = extended_write_lock[ext_lock_pkg::BIT_PASSKEY];
  wire logic restore_cmd_lock      = extended_write_lock[ext_lock_pkg::BIT_RESTORE];
  wire logic store_cmd_lock        = extended_write_lock[ext_lock_pkg::BIT_STORE];
  wire logic protect_cfg_lock      = extended_write_lock[ext_lock_pkg::BIT_PROTECT];

  wire logic hit_warning = in_set(c, ext_lock_pkg::CMD_ALERT_MASK, ext_lock_pkg::CMD_VOUT_OV_WARN,
    ext_lock_pkg::CMD_VOUT_UV_WARN, ext_lock_pkg::CMD_IOUT_OC_WARN, ext_lock_pkg::CMD_OT_WARN);
  wire logic hit_cur_temp = in_set(c, ext_lock_pkg::CMD_IOUT_OC_FAULT, ext_lock_pkg::CMD_IOUT_OC_RESP,
    ext_lock_pkg::CMD_OT_FAULT, ext_lock_pkg::CMD_OT_RESP, ext_lock_pkg::CMD_OT_RESP);
  wire logic hit_margin = in_set(c, ext_lock_pkg::CMD_MARGIN_HIGH, ext_lock_pkg::CMD_MARGIN_LOW,
    ext_lock_pkg::CMD_TRANS_RATE, ext_lock_pkg::CMD_TRANS_RATE, ext_lock_pkg::CMD_TRANS_RATE);
  wire logic hit_device_cfg = in_set(c, ext_lock_pkg::CMD_FREQ_SWITCH, CMD_USER_SYSCFG,
    CMD_BUS_ADDR, CMD_COMP, CMD_COMP);
  wire logic hit_seq_a = in_set(c, ext_lock_pkg::CMD_TON_DELAY, ext_lock_pkg::CMD_TON_RISE,
    ext_lock_pkg::CMD_TOFF_DELAY, ext_lock_pkg::CMD_TOFF_FALL, ext_lock_pkg::CMD_ON_OFF_CONFIG);
  wire logic hit_seq = hit_seq_a || (c == ext_lock_pkg::CMD_VIN_ON) || (c == ext_lock_pkg::CMD_VIN_OFF);
  wire logic hit_maker = in_set(c, ext_lock_pkg::CMD_MAKER_ID, ext_lock_pkg::CMD_MAKER_MODEL,
    ext_lock_pkg::CMD_MAKER_REV, ext_lock_pkg::CMD_MAKER_REV, ext_lock_pkg::CMD_MAKER_REV);
  wire logic hit_protect = (c == ext_lock_pkg::CMD_EXT_LOCK) || (c == ext_lock_pkg::CMD_WRITE_PROTECT);

  // Store and restore share the store lock; a store done while it is set carries it into the effective lock at the next reload
  wire logic store_blocked   = store_lock_eff || store_cmd_lock;
  wire logic restore_blocked = restore_cmd_lock || store_cmd_lock;

  wire logic ext_block =
      (warning_cfg_lock && hit_warning)
    | (current_temp_fault_lock && hit_cur_temp)
    | (margin_cfg_lock && hit_margin)
    | (operation_cmd_lock && (c == ext_lock_pkg::CMD_OPERATION))
    | (device_cfg_lock && hit_device_cfg)
    | (input_fault_cfg_lock && (c == ext_lock_pkg::CMD_VIN_OV_FAULT))
    | (sequencing_cfg_lock && hit_seq)
    | (maker_data_lock && hit_maker)
    | (passkey_cmd_lock && (c == CMD_PASSKEY))
    | (restore_blocked && (c == ext_lock_pkg::CMD_RESTORE_ALL))
    | (store_blocked && (c == ext_lock_pkg::CMD_STORE_ALL))
    | (protect_cfg_lock && hit_protect);

  // Extended locks add to standard protection, never relax it
  wire logic write_ok = !ext_block && !i_std_protect_block;

  assign o_wr_accept = i_wr_valid && write_ok;
  assign o_wr_refuse = i_wr_valid && !write_ok;

  wire logic lock_write = o_wr_accept && i_ce && (c == ext_lock_pkg::CMD_EXT_LOCK);

  // Protect bit only ever ORs in
  wire logic [15:0] next_lock_word =
    (i_wr_data & ext_lock_pkg::LOCK_WRITE_MASK) |
    (extended_write_lock & (16'h0001 << ext_lock_pkg::BIT_PROTECT));

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      extended_write_lock <= ext_lock_pkg::LOCK_RESET;
    end else if (i_ce && i_nvm_load_valid) begin
      extended_write_lock <= i_nvm_load_data & ext_lock_pkg::LOCK_WRITE_MASK;
    end else if (lock_write) begin
      extended_write_lock <= next_lock_word;
    end
  end

  // Effective store lock follows memory contents only at a reload
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      store_lock_eff <= 1'b0;
      store_pending  <= 1'b0;
    end else if (i_ce) begin
      if (i_nvm_load_valid) begin
        store_lock_eff <= i_nvm_load_data[ext_lock_pkg::BIT_STORE] | store_pending;
        store_pending  <= 1'b0;
      end else if (i_store_done) begin
        store_pending <= store_cmd_lock;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_lock_word <= ext_lock_pkg::LOCK_RESET;
    end else if (i_ce) begin
      o_lock_word <= extended_write_lock & ext_lock_pkg::LOCK_WRITE_MASK;
    end
  end

  assign o_store_lock_active    = store_blocked;
  assign o_store_allow          = !store_blocked;
  assign o_restore_allow        = !restore_blocked;
  assign o_passkey_unlock_allow = !passkey_cmd_lock;

endmodule : extended_write_protect_lock
`default_nettype wire

// ---- ext_lock_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module ext_lock_props (
  input wire logic        i_core_clk,
  input wire logic        i_reset,
  input wire logic        i_ce,
  input wire logic        i_wr_valid,
  input wire logic [7:0]  i_cmd_code,
  input wire logic [15:0] i_wr_data,
  input wire logic        i_nvm_load_valid,
  input wire logic [15:0] i_nvm_load_data,
  input wire logic        o_wr_accept,
  input wire logic        o_wr_refuse,
  input wire logic [15:0] o_lock_word,
  input wire logic        o_store_allow,
  input wire logic        o_passkey_unlock_allow
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Load in the same cycle beats a lock word write
  sequence s_dd_taken;
    i_wr_valid && i_ce && o_wr_accept && i_cmd_code == ext_lock_pkg::CMD_EXT_LOCK && !i_nvm_load_valid;
  endsequence
  a_one_answer: assert property (i_wr_valid |-> o_wr_accept != o_wr_refuse)
    else $error("write answer not unique");
  a_top_bit_zero: assert property (o_lock_word[15] == 1'b0)
    else $error("top lock bit set");
  a_dd_lands: assert property (s_dd_taken ##1 i_ce |=> o_lock_word == ($past(i_wr_data, 2) & 16'h7fff))
    else $error("lock word write lost");
  a_load_lands: assert property (i_nvm_load_valid && i_ce ##1 i_ce |=> o_lock_word == ($past(i_nvm_load_data, 2) & 16'h7fff))
    else $error("lock word load lost");
  // Readback lags the live word by one cycle
  a_passkey_gate: assert property ($past(i_ce) |-> o_lock_word[2] == !$past(o_passkey_unlock_allow))
    else $error("passkey unlock gate wrong");
  a_store_gate: assert property ($past(i_ce) && o_lock_word[0] |-> !$past(o_store_allow))
    else $error("store allowed while locked");
  a_op_locked: assert property ($past(i_wr_valid) && $past(i_cmd_code) == 8'h01 && o_lock_word[7] |-> $past(o_wr_refuse))
    else $error("operation write not refused");
  a_protect_locked: assert property ($past(i_wr_valid) && $past(i_cmd_code) == 8'h10 && o_lock_word[14] |-> $past(o_wr_refuse))
    else $error("protect write not refused");
endmodule : ext_lock_props
bind extended_write_protect_lock ext_lock_props u_props (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_ce(i_ce),
  .i_wr_valid(i_wr_valid), .i_cmd_code(i_cmd_code), .i_wr_data(i_wr_data), .i_nvm_load_valid(i_nvm_load_valid),
  .i_nvm_load_data(i_nvm_load_data), .o_wr_accept(o_wr_accept), .o_wr_refuse(o_wr_refuse), .o_lock_word(o_lock_word),
  .o_store_allow(o_store_allow), .o_passkey_unlock_allow(o_passkey_unlock_allow));
`default_nettype wire

// ---- host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_wr_accept,
  output logic             o_wr_valid = 1'b0,
  output logic [7:0]       o_cmd_code = 8'h00,
  output logic [15:0]      o_wr_data = 16'h0000
);
  // Whole 16-bit word per write; idle lines show inverted data so stale values never pass
  task automatic send(input logic [7:0] cmd, input logic [15:0] data, output logic accepted);
    @(posedge i_core_clk) #1;
    {o_wr_valid, o_cmd_code, o_wr_data} = {1'b1, cmd, data};
    // Answer taken at the edge that commits the write, request held until then
    @(posedge i_core_clk);
    accepted = i_wr_accept;
    #1;
    {o_wr_valid, o_cmd_code, o_wr_data} = {1'b0, ~cmd, ~data};
  endtask : send
endmodule : host_model
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        core_clk = 1'b0, reset = 1'b1, std_block = 1'b0, load_valid = 1'b0, store_done = 1'b0, acc;
  logic        wr_valid, wr_accept, store_allow, restore_allow, passkey_allow, store_active, ce = 1'b1;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data, lock_word, load_data = 16'h0000;
  logic [7:0]  grp_code [0:10] = '{8'h15, 8'h16, 8'hf0, 8'h9a, 8'h02, 8'h55, 8'h33, 8'h01, 8'h26, 8'h4f, 8'h42};
  int          fail_count = 0, total_checks = 0;
  always #20 core_clk = ~core_clk;
  host_model u_host (.i_core_clk(core_clk), .i_wr_accept(wr_accept), .o_wr_valid(wr_valid), .o_cmd_code(cmd_code),
    .o_wr_data(wr_data));
  extended_write_protect_lock u_dut (.i_core_clk(core_clk), .i_reset(reset), .i_ce(ce), .i_wr_valid(wr_valid),
    .i_cmd_code(cmd_code), .i_wr_data(wr_data), .i_std_protect_block(std_block), .i_nvm_load_valid(load_valid),
    .i_nvm_load_data(load_data), .i_store_done(store_done), .o_wr_accept(wr_accept), .o_wr_refuse(),
    .o_lock_word(lock_word), .o_store_lock_active(store_active), .o_store_allow(store_allow),
    .o_restore_allow(restore_allow),
    .o_passkey_unlock_allow(passkey_allow));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data, input logic exp);
    u_host.send(cmd, data, acc);
    check({15'h0000, acc}, {15'h0000, exp});
  endtask : wr
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic pulse(ref logic sig);
    @(posedge core_clk) #1 sig = 1'b1;
    @(posedge core_clk) #1 sig = 1'b0;
    settle();
  endtask : pulse
  task automatic t_groups;
    for (int b = 0; b <= 10; b++) begin
      wr(grp_code[b], 16'h00a5, 1'b1);
      wr(8'hdd, 16'h0001 << b, 1'b1);
      settle();
      check(lock_word, 16'h0001 << b);
      wr(grp_code[b], 16'h005a, 1'b0);
      check({14'h0000, passkey_allow, restore_allow}, {14'h0000, b != 2, b > 1});
      wr(8'hdd, 16'h0000, 1'b1);
    end
    $display("group lock test done");
  endtask : t_groups
  task automatic t_std;
    std_block = 1'b1;
    wr(8'h42, 16'h0000, 1'b0);
    std_block = 1'b0;
    // Clock enable low must freeze the lock word
    ce = 1'b0;
    u_host.send(8'hdd, 16'h0010, acc);
    ce = 1'b1;
    settle();
    check(lock_word, 16'h0000);
    $display("standard protect test done");
  endtask : t_std
  task automatic t_store;
    wr(8'hdd, 16'h0001, 1'b1);
    check({14'h0000, store_active, store_allow}, 16'h0002);
    pulse(store_done);
    wr(8'hdd, 16'h0000, 1'b1);
    pulse(load_valid);
    check({15'h0000, store_allow}, 16'h0000);
    pulse(reset);
    load_data = 16'h0002;
    pulse(load_valid);
    check(lock_word, 16'h0002);
    load_data = 16'h0001;
    pulse(load_valid);
    wr(8'h15, 16'h0000, 1'b0);
    $display("store lock test done");
  endtask : t_store
  task automatic t_protect;
    wr(8'hdd, 16'hc000, 1'b1);
    settle();
    check(lock_word, 16'h4000);
    wr(8'hdd, 16'h0000, 1'b0);
    wr(8'h10, 16'h0000, 1'b0);
    settle();
    check(lock_word, 16'h4000);
    $display("protect lock test done");
  endtask : t_protect
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge core_clk);
    #1 reset = 1'b0;
    t_groups();
    t_std();
    t_store();
    t_protect();
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
